// *** inc/image_handshake_pkg.sv ***
// Constants, register map and state encoding for the process-image handshake block.
package image_handshake_pkg;

  // ****************************************
  // Control and status byte layout
  // ****************************************
  localparam int REG_MODE_BIT = 7;
  localparam int WRITE_BIT = 6;
  localparam int CFG_INDEX_W = 6;
  localparam int SEND_REQUEST_BIT = 0;
  localparam int RX_TAKEN_BIT = 1;
  localparam int INIT_REQUEST_BIT = 2;
  localparam int BUF_FULL_BIT = 3;
  localparam int COUNT_LSB = 4;
  localparam int COUNT_W = 3;

  // ****************************************
  // Image geometry
  // ****************************************
  localparam int IMAGE_BYTES = 6;
  localparam logic [2:0] MIN_DATA_BYTES = 3'h1;
  localparam logic [2:0] MAX_DATA_BYTES = 3'h5;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [5:0] SEND_COUNT_OFS = 6'h00;
  localparam logic [5:0] RX_COUNT_OFS = 6'h01;
  localparam logic [5:0] DIAG_ERROR_BITS_OFS = 6'h06;
  localparam logic [5:0] TYPE_CODE_OFS = 6'h08;
  localparam logic [5:0] FULL_THRESHOLD_OFS = 6'h12;
  localparam logic [5:0] BAUD_OFS = 6'h20;
  localparam logic [5:0] FRAME_OFS = 6'h21;
  localparam logic [5:0] FEATURE_OFS = 6'h22;
  localparam logic [5:0] MAPPED_BYTE_COUNT_OFS = 6'h23;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] FULL_THRESHOLD_RST = 16'h0080;
  localparam logic [15:0] BAUD_RST = 16'h0006;
  localparam logic [15:0] FRAME_RST = 16'h0003;
  localparam logic [15:0] FEATURE_RST = 16'h0003;
  localparam logic [15:0] MAPPED_BYTE_COUNT_RST = 16'h0003;

  // ****************************************
  // Diagnostic bits
  // ****************************************
  localparam int DIAG_OVERFLOW_BIT = 0;
  localparam int DIAG_PARITY_BIT = 1;
  localparam int DIAG_FRAMING_BIT = 2;
  localparam int DIAG_OVERRUN_BIT = 3;
  localparam int DIAG_FULL_BIT = 4;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_INIT  = 4'b1000
  } state_type;

endpackage : image_handshake_pkg

// *** inc/fifo_ram_if.sv ***
// Port bundle between a FIFO owner and its byte store.
`timescale 1ns/10ps
`default_nettype none
interface fifo_ram_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic ce;
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport owner (output ce, we, waddr, wdata, re, raddr, input rdata);
  modport store (input ce, we, waddr, wdata, re, raddr, output rdata);
endinterface : fifo_ram_if
`default_nettype wire

// *** core/byte_store.sv ***
// Simple dual-port byte memory with registered read data.
`timescale 1ns/10ps
`default_nettype none
module byte_store #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk, // System clock.
  fifo_ram_if.store port // Write and read port.
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (port.ce && port.we) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (port.ce && port.re) begin
      port.rdata <= mem[port.raddr];
    end
  end

endmodule : byte_store
`default_nettype wire

// *** core/serial_terminal_image_handshake.sv ***
// Process-image handshake and register access for a serial bus terminal.
//
// Summary of operation
// [R1] Mapped byte count 1..5, default 3.
// [R2] Control bit 7 selects register access.
// [R3] Bit 6: 0 reads, 1 writes register.
// [R4] Controller waits for write acknowledge status.
// [R5] Control bits 5..0 address 64 registers.
// [R6] Status byte lowest, value in next two.
// [R7] Padded variant skips one byte first.
// [R8] Write answer echoes address with bit 7.
// [R9] Controller control byte process-data layout.
// [R10] Device status byte process-data layout.
// [R11] Send toggle loads counted bytes to FIFO.
// [R12] Send done mirrors request after loading.
// [R13] Present bytes, count, then toggle offer.
// [R14] New receive data only after taken.
// [R15] Init disables link, resets, reloads config.
// [R16] Init done raised, then cleared after request.
// [R17] Buffer full flags and discards input.
// [R18] Erroneous characters are never stored.
// [R19] Each error sets its diagnostic bit.
// [R20] Full once count reaches threshold.
// [R21] Diagnostic bits: overflow, parity, framing, overrun, full.
// [R22] Reset clears acknowledges and both FIFOs.
`timescale 1ns/10ps
`default_nettype none
module serial_terminal_image_handshake
  import image_handshake_pkg::*;
#(
  parameter int FIFO_AW = 8,
  parameter logic [15:0] TYPE_CODE = 16'h5a5a // Arbitrary identification value.
) (
  input wire logic clk, // 100 MHz system clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic pad_align, // Coupler inserts a pad byte before register values.
  input wire logic [8*IMAGE_BYTES-1:0] out_image, // Output image, byte 0 is control.
  output logic [8*IMAGE_BYTES-1:0] in_image, // Input image, byte 0 is status.
  output logic [7:0] tx_data, // Byte toward the serial transmitter.
  output logic tx_valid, // Transmit byte valid.
  input wire logic tx_ready, // Transmitter takes the byte.
  input wire logic [7:0] rx_data, // Byte from the serial receiver.
  input wire logic rx_valid, // Received byte strobe.
  input wire logic rx_parity_err, // Received byte has a parity error.
  input wire logic rx_frame_err, // Received byte has a framing error.
  input wire logic rx_overrun_err, // Received byte has an overrun error.
  output logic link_enable, // Sending and receiving enabled.
  output logic [15:0] baud_cfg, // Active baud setting.
  output logic [15:0] frame_cfg, // Active frame setting.
  output logic [15:0] feature_cfg // Active feature setting.
);

  localparam int CW = FIFO_AW + 1;
  localparam logic [CW-1:0] DEPTH = CW'(1 << FIFO_AW);

  // ****************************************
  // Control byte decode
  // ****************************************
  wire logic [7:0] ctrl_byte = out_image[7:0];
  wire logic reg_mode = ctrl_byte[REG_MODE_BIT]; // [R2]
  wire logic reg_write = ctrl_byte[WRITE_BIT]; // [R3]
  wire logic [CFG_INDEX_W-1:0] cfg_index_bits = ctrl_byte[CFG_INDEX_W-1:0]; // [R5]
  wire logic [COUNT_W-1:0] out_count_field = ctrl_byte[COUNT_LSB +: COUNT_W]; // [R9]
  wire logic send_request_toggle = ctrl_byte[SEND_REQUEST_BIT];
  wire logic rx_taken_toggle = ctrl_byte[RX_TAKEN_BIT];
  wire logic init_request = ctrl_byte[INIT_REQUEST_BIT];
  wire logic [2:0] hi_pos = pad_align ? 3'h2 : 3'h1; // [R6] [R7]
  wire logic [15:0] wr_value = {out_image[8*hi_pos +: 8], out_image[8*(hi_pos+3'h1) +: 8]};

  function automatic logic [2:0] clamp_count(input logic [7:0] v, input logic [2:0] lim);
    logic [7:0] c;
    c = (v < 8'(MIN_DATA_BYTES)) ? 8'(MIN_DATA_BYTES) : v;
    c = (c > 8'(MAX_DATA_BYTES)) ? 8'(MAX_DATA_BYTES) : c;
    return (c[2:0] > lim) ? lim : c[2:0];
  endfunction : clamp_count

  // ****************************************
  // State
  // ****************************************
  state_type state_q, state_d;
  logic [15:0] threshold_q, baud_q, frame_q, feature_q, mapped_q;
  logic [15:0] baud_act_q, frame_act_q, feature_act_q;
  logic [2:0] map_act_q;
  logic comm_en_q;
  logic send_done_q, rx_offer_q, init_done_q;
  logic [2:0] in_count_q;
  logic [3:0] diag_q;
  logic [7:0] rx_hold_q [0:MAX_DATA_BYTES-1];
  logic [2:0] load_idx_q, load_n_q, issue_idx_q, cap_idx_q, fetch_n_q;
  logic rd_pend_q;
  logic [FIFO_AW-1:0] tx_wptr_q, tx_rptr_q, rx_wptr_q, rx_rptr_q;
  logic [CW-1:0] tx_cnt_q, rx_cnt_q;
  logic tx_valid_q;
  logic [8*IMAGE_BYTES-1:0] in_image_q;

  fifo_ram_if #(.AW(FIFO_AW), .DW(8)) tx_ram ();
  fifo_ram_if #(.AW(FIFO_AW), .DW(8)) rx_ram ();

  byte_store #(.AW(FIFO_AW), .DW(8)) tx_store (.clk(clk), .port(tx_ram));
  byte_store #(.AW(FIFO_AW), .DW(8)) rx_store (.clk(clk), .port(rx_ram));

  // ****************************************
  // Handshake sequencer
  // ****************************************
  wire logic in_init = (state_q == ST_INIT);
  wire logic in_load = (state_q == ST_LOAD);
  wire logic in_fetch = (state_q == ST_FETCH);
  wire logic in_idle = (state_q == ST_IDLE);
  wire logic send_pending = (send_request_toggle != send_done_q); // [R11]
  wire logic rx_free = (rx_offer_q == rx_taken_toggle); // [R14]
  wire logic go_init = in_idle && !reg_mode && init_request;
  wire logic go_load = in_idle && !reg_mode && !init_request && send_pending;
  wire logic go_fetch = in_idle && !reg_mode && !init_request && !send_pending && rx_free &&
                        (rx_cnt_q != '0) && comm_en_q; // [R13] [R14]
  wire logic load_end = in_load && (load_idx_q == load_n_q);
  wire logic fetch_end = in_fetch && (cap_idx_q == fetch_n_q) && !rd_pend_q;
  wire logic init_end = in_init && init_done_q && !reg_mode && !init_request; // [R16]
  wire logic [2:0] rx_avail = (rx_cnt_q > CW'(MAX_DATA_BYTES)) ? MAX_DATA_BYTES : rx_cnt_q[2:0];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (go_init) begin
          state_d = ST_INIT;
        end else if (go_load) begin
          state_d = ST_LOAD;
        end else if (go_fetch) begin
          state_d = ST_FETCH;
        end
      end
      ST_LOAD: begin
        if (load_end) begin
          state_d = ST_IDLE;
        end
      end
      ST_FETCH: begin
        if (fetch_end) begin
          state_d = ST_IDLE;
        end
      end
      ST_INIT: begin
        if (init_end) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Handshake bits
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      send_done_q <= 1'b0; // [R22]
      rx_offer_q <= 1'b0;
      init_done_q <= 1'b0;
      in_count_q <= 3'h0;
      comm_en_q <= 1'b1;
    end else if (clk_en) begin
      if (load_end) begin
        send_done_q <= send_request_toggle; // [R12]
      end
      if (fetch_end) begin
        in_count_q <= fetch_n_q; // [R13]
        rx_offer_q <= ~rx_offer_q;
      end
      if (in_init) begin
        init_done_q <= !init_end; // [R16]
        comm_en_q <= init_end; // [R15]
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  wire logic reg_wr = reg_mode && reg_write; // [R3]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      threshold_q <= FULL_THRESHOLD_RST;
      baud_q <= BAUD_RST;
      frame_q <= FRAME_RST;
      feature_q <= FEATURE_RST;
      mapped_q <= MAPPED_BYTE_COUNT_RST; // [R1]
    end else if (clk_en && reg_wr) begin
      if (cfg_index_bits == FULL_THRESHOLD_OFS) threshold_q <= wr_value;
      if (cfg_index_bits == BAUD_OFS) baud_q <= wr_value;
      if (cfg_index_bits == FRAME_OFS) frame_q <= wr_value;
      if (cfg_index_bits == FEATURE_OFS) feature_q <= wr_value;
      if (cfg_index_bits == MAPPED_BYTE_COUNT_OFS) mapped_q <= wr_value;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      baud_act_q <= BAUD_RST;
      frame_act_q <= FRAME_RST;
      feature_act_q <= FEATURE_RST;
      map_act_q <= MAPPED_BYTE_COUNT_RST[2:0];
    end else if (clk_en && in_init) begin
      baud_act_q <= baud_q; // [R15]
      frame_act_q <= frame_q;
      feature_act_q <= feature_q;
      map_act_q <= clamp_count(mapped_q[7:0], MAX_DATA_BYTES); // [R1]
    end
  end

  // The count is widened and the threshold cut to its low byte; a FIFO at DEPTH reads as full whatever the threshold.
  wire logic [15:0] rx_cnt_w = 16'(rx_cnt_q);
  wire logic buf_full = (rx_cnt_w >= {8'h00, threshold_q[7:0]}) || (rx_cnt_q == DEPTH); // [R20]
  wire logic [15:0] rd_value =
    (cfg_index_bits == SEND_COUNT_OFS) ? {8'h00, 8'(tx_cnt_q)} :
    (cfg_index_bits == RX_COUNT_OFS) ? {8'h00, 8'(rx_cnt_q)} :
    (cfg_index_bits == DIAG_ERROR_BITS_OFS) ? {11'h000, buf_full, diag_q} : // [R21]
    (cfg_index_bits == TYPE_CODE_OFS) ? TYPE_CODE :
    (cfg_index_bits == FULL_THRESHOLD_OFS) ? {8'h00, threshold_q[7:0]} :
    (cfg_index_bits == BAUD_OFS) ? baud_q :
    (cfg_index_bits == FRAME_OFS) ? frame_q :
    (cfg_index_bits == FEATURE_OFS) ? feature_q :
    (cfg_index_bits == MAPPED_BYTE_COUNT_OFS) ? {8'h00, mapped_q[7:0]} : 16'h0000; // [R1]

  // ****************************************
  // Send path
  // ****************************************
  wire logic tx_push = in_load && !load_end && (tx_cnt_q != DEPTH); // [R11]
  wire logic tx_pop = comm_en_q && (tx_cnt_q != '0) && (!tx_valid_q || tx_ready);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      load_idx_q <= 3'h0;
      load_n_q <= 3'h0;
    end else if (clk_en) begin
      if (go_load) begin
        load_idx_q <= 3'h0;
        load_n_q <= (out_count_field > map_act_q) ? map_act_q : out_count_field; // [R11]
      end else if (tx_push) begin
        load_idx_q <= load_idx_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || (clk_en && in_init)) begin
      tx_wptr_q <= '0; // [R15] [R22]
      tx_rptr_q <= '0;
      tx_cnt_q <= '0;
      tx_valid_q <= 1'b0;
    end else if (clk_en) begin
      tx_wptr_q <= tx_wptr_q + FIFO_AW'(tx_push);
      tx_rptr_q <= tx_rptr_q + FIFO_AW'(tx_pop);
      tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
      if (tx_pop) begin
        tx_valid_q <= 1'b1;
      end else if (tx_ready) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  assign tx_ram.ce = clk_en;
  assign tx_ram.we = tx_push;
  assign tx_ram.waddr = tx_wptr_q;
  assign tx_ram.wdata = out_image[8*(load_idx_q+3'h1) +: 8];
  assign tx_ram.re = tx_pop;
  assign tx_ram.raddr = tx_rptr_q;

  // ****************************************
  // Receive path
  // ****************************************
  wire logic rx_bad = rx_parity_err || rx_frame_err || rx_overrun_err;
  wire logic rx_good = rx_valid && comm_en_q && !in_init && !rx_bad; // [R18]
  wire logic rx_push = rx_good && !buf_full; // [R17]
  wire logic rx_pop = in_fetch && (issue_idx_q != fetch_n_q);

  always_ff @(posedge clk) begin
    if (sys_rst || (clk_en && in_init)) begin
      rx_wptr_q <= '0; // [R15] [R22]
      rx_rptr_q <= '0;
      rx_cnt_q <= '0;
    end else if (clk_en) begin
      rx_wptr_q <= rx_wptr_q + FIFO_AW'(rx_push);
      rx_rptr_q <= rx_rptr_q + FIFO_AW'(rx_pop);
      rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || (clk_en && in_init)) begin
      diag_q <= 4'h0;
    end else if (clk_en && rx_valid && comm_en_q) begin
      diag_q[DIAG_OVERFLOW_BIT] <= diag_q[DIAG_OVERFLOW_BIT] | (rx_good && buf_full); // [R19]
      diag_q[DIAG_PARITY_BIT] <= diag_q[DIAG_PARITY_BIT] | rx_parity_err;
      diag_q[DIAG_FRAMING_BIT] <= diag_q[DIAG_FRAMING_BIT] | rx_frame_err;
      diag_q[DIAG_OVERRUN_BIT] <= diag_q[DIAG_OVERRUN_BIT] | rx_overrun_err;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      issue_idx_q <= 3'h0;
      cap_idx_q <= 3'h0;
      fetch_n_q <= 3'h0;
      rd_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (go_fetch) begin
        issue_idx_q <= 3'h0;
        cap_idx_q <= 3'h0;
        fetch_n_q <= (rx_avail > map_act_q) ? map_act_q : rx_avail; // [R13]
      end else begin
        issue_idx_q <= issue_idx_q + 3'(rx_pop);
        cap_idx_q <= cap_idx_q + 3'(rd_pend_q);
      end
      rd_pend_q <= rx_pop;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_hold_q <= '{default: 8'h00}; // [R22]
    end else if (clk_en && rd_pend_q) begin
      rx_hold_q[cap_idx_q] <= rx_ram.rdata; // [R13]
    end
  end

  assign rx_ram.ce = clk_en;
  assign rx_ram.we = rx_push;
  assign rx_ram.waddr = rx_wptr_q;
  assign rx_ram.wdata = rx_data;
  assign rx_ram.re = rx_pop;
  assign rx_ram.raddr = rx_rptr_q;

  // ****************************************
  // Input image
  // ****************************************
  wire logic [7:0] reg_status = {1'b1, 1'b0, cfg_index_bits}; // [R8]
  wire logic [7:0] pd_status = {1'b0, in_count_q, buf_full, init_done_q, rx_offer_q,
                                send_done_q}; // [R10]
  wire logic [8*IMAGE_BYTES-1:0] img_flat;

  assign img_flat[7:0] = reg_mode ? reg_status : pd_status; // [R6]

  genvar k;
  generate
    for (k = 1; k < IMAGE_BYTES; k++) begin : g_img
      wire logic [7:0] reg_byte =
        reg_write ? 8'h00 : // [R8]
        (3'(k) == hi_pos) ? rd_value[15:8] :
        (3'(k) == hi_pos + 3'h1) ? rd_value[7:0] : 8'h00; // [R3] [R7]
      assign img_flat[8*k +: 8] = reg_mode ? reg_byte : rx_hold_q[k-1];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_image_q <= '0;
    end else if (clk_en) begin
      in_image_q <= img_flat;
    end
  end

  assign in_image = in_image_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_ram.rdata;
  assign link_enable = comm_en_q;
  assign baud_cfg = baud_act_q;
  assign frame_cfg = frame_act_q;
  assign feature_cfg = feature_act_q;

endmodule : serial_terminal_image_handshake
`default_nettype wire

// *** verification/image_port_chk.sv ***
// Port-level assertions for the process-image handshake block.
`timescale 1ns/10ps
`default_nettype none
module image_port_chk
  import image_handshake_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic clk_en, // Run enable.
  input wire logic pad_align, // Pad byte in use.
  input wire logic [8*IMAGE_BYTES-1:0] out_image, // Controller image.
  input wire logic [8*IMAGE_BYTES-1:0] in_image, // Device image.
  input wire logic [7:0] tx_data, // Transmit byte.
  input wire logic tx_valid, // Transmit valid.
  input wire logic tx_ready, // Transmit taken.
  input wire logic link_enable // Link running.
);
  wire logic [7:0] cb = out_image[7:0];
  wire logic [7:0] sb = in_image[7:0];

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_WRITE_ECHO: assert property (clk_en && cb[7:6] == 2'b11 |=>
    sb == {2'b10, $past(cb[5:0])} && in_image[47:8] == '0) else $error("write answer wrong");
  AST_READ_STATUS: assert property (clk_en && cb[7:6] == 2'b10 |=>
    sb == {2'b10, $past(cb[5:0])}) else $error("read status wrong");
  AST_READ_PAD: assert property (clk_en && cb[7:6] == 2'b10 && pad_align |=>
    in_image[15:8] == 8'h00 && in_image[47:32] == '0) else $error("pad byte not empty");
  AST_PROC_STATUS: assert property (clk_en && !cb[7] |=>
    !sb[7] && sb[6:4] <= 3'h5) else $error("process status malformed");
  AST_INIT_LINK_OFF: assert property (clk_en && !cb[7] && cb[2] |->
    ##[1:20] !link_enable) else $error("link still running in init");
  AST_INIT_LINK_BACK: assert property (clk_en && !link_enable && !cb[7] && !cb[2] |->
    ##[1:3] link_enable) else $error("link not restored after init");
  AST_RX_HOLD: assert property ((clk_en && !cb[7] && !sb[7] && sb[1] != cb[1]
    && $stable(cb[1])) [*3] |=> $stable(sb[1])) else $error("offer moved before taken");
  AST_TX_HOLD: assert property (clk_en && tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("transmit byte dropped or changed");
  AST_RESET_IDLE: assert property (disable iff (1'b0) sys_rst && clk_en |=>
    in_image == '0 && !tx_valid && link_enable) else $error("reset state wrong");
endmodule : image_port_chk
`default_nettype wire

// *** verification/uart_end_model.sv ***
// Serial-side model: stalling transmit sink and receive byte source.
`timescale 1ns/10ps
`default_nettype none
module uart_end_model (
  input wire logic clk, // System clock.
  output logic tx_ready, // Transmit byte taken.
  output logic [7:0] rx_data, // Received byte.
  output logic rx_valid, // One-cycle receive strobe.
  output logic [2:0] rx_err // Overrun, framing, parity flags.
);
  initial begin
    tx_ready <= 1'b0;
    rx_valid <= 1'b0;
    rx_data <= 8'h00;
    rx_err <= 3'h0;
  end

  // Stalls on about a quarter of cycles so the block must hold its byte.
  always @(posedge clk) begin
    tx_ready <= ($urandom_range(3) != 0);
  end

  // Between strobes the data and flags show the inverse, never the last byte.
  task automatic put(input logic [7:0] d, input logic [2:0] e);
    @(posedge clk);
    rx_data <= d;
    rx_err <= e;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_err <= ~e;
  endtask : put
endmodule : uart_end_model
`default_nettype wire

// *** verification/serial_terminal_image_handshake_test.sv ***
// Self-checking bench for the process-image handshake block.
`timescale 1ns/10ps
`default_nettype none
module serial_terminal_image_handshake_test
  import image_handshake_pkg::*;
();
  localparam logic [15:0] TYPE_VAL = 16'h3c96; // Arbitrary identification value.
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pad_align = 1'b0;
  logic [47:0] out_image = '0;
  logic [47:0] in_image;
  logic [7:0] tx_data, rx_data;
  logic tx_valid, tx_ready, rx_valid, link_enable;
  logic [2:0] rx_err;
  logic [15:0] baud_cfg, frame_cfg, feature_cfg;
  logic clk_en = 1'b1;
  logic taken_tgl_q = 1'b0;
  logic send_tgl_q = 1'b0;
  logic [7:0] txq[$];
  int n_errors = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  serial_terminal_image_handshake #(.FIFO_AW(4), .TYPE_CODE(TYPE_VAL))
    i_serial_terminal_image_handshake (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .pad_align(pad_align),
    .out_image(out_image), .in_image(in_image), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_err(rx_err[0]),
    .rx_frame_err(rx_err[1]), .rx_overrun_err(rx_err[2]), .link_enable(link_enable),
    .baud_cfg(baud_cfg), .frame_cfg(frame_cfg), .feature_cfg(feature_cfg));

  uart_end_model i_uart_end_model (.clk(clk), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_err(rx_err));

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Transfers are judged at the falling edge, where ready and valid are settled.
  always @(negedge clk) begin
    if (!sys_rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      chk("tx_byte", 48'(tx_data), txq.size() > 0 ? 48'(txq.pop_front()) : 48'h100);
    end
  end

  task automatic img(input logic [47:0] v, input logic pad = 1'b0);
    @(posedge clk);
    out_image <= v;
    pad_align <= pad;
    @(posedge clk);
    #1;
  endtask : img

  task automatic wait_st(input int b, input logic v);
    int i;
    for (i = 0; i < 300 && in_image[b] !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk("status_bit", 48'(in_image[b]), 48'(v));
    if (i == 300) give_verdict();
  endtask : wait_st

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    img({24'h0, v[7:0], v[15:8], 2'b11, a});
    chk("write_status", 48'(in_image[7:0]), 48'({2'b10, a}));
    chk("write_data", 48'(in_image[47:8]), 48'h0);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic pad, input logic [15:0] e);
    img({40'h0, 2'b10, a}, pad);
    chk("read_status", 48'(in_image[7:0]), 48'({2'b10, a}));
    chk("read_value", pad ? 48'(in_image[31:16]) : 48'(in_image[23:8]), 48'({e[7:0], e[15:8]}));
  endtask : rd

  task automatic ctl(input logic [2:0] oc, input logic init_req, input logic [39:0] d);
    img({d, 1'b0, oc, 1'b0, init_req, taken_tgl_q, send_tgl_q});
  endtask : ctl

  task automatic send(input logic [2:0] oc, input int n);
    logic [39:0] d;
    d = 40'({$urandom(), $urandom()});
    for (int k = 0; k < n; k++) txq.push_back(d[8*k +: 8]);
    send_tgl_q = ~send_tgl_q;
    ctl(oc, 1'b0, d);
    wait_st(0, send_tgl_q);
  endtask : send

  task automatic drain();
    for (int i = 0; i < 500 && txq.size() > 0; i++) @(posedge clk);
    chk("tx_left", 48'(txq.size()), 48'h0);
    if (txq.size() > 0) give_verdict();
  endtask : drain

  initial begin
    void'($urandom(2));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset_image", in_image, 48'h0);
    chk("reset_link", 48'(link_enable), 48'h1);
    chk("reset_baud", 48'(baud_cfg), 48'(BAUD_RST));
    chk("reset_frame", 48'(frame_cfg), 48'(FRAME_RST));
    chk("reset_feature", 48'(feature_cfg), 48'(FEATURE_RST));
    // A frozen block must not take the write held at its image.
    clk_en <= 1'b0;
    img({24'h0, 16'h0100, 2'b11, FULL_THRESHOLD_OFS});
    chk("frozen_image", in_image, 48'h0);
    img(48'h0);
    clk_en <= 1'b1;
    rd(MAPPED_BYTE_COUNT_OFS, 1'b0, MAPPED_BYTE_COUNT_RST);
    rd(FULL_THRESHOLD_OFS, 1'b1, FULL_THRESHOLD_RST);
    rd(TYPE_CODE_OFS, 1'b1, TYPE_VAL);
    rd(6'h02, 1'b0, 16'h0000);
    wr(RX_COUNT_OFS, 16'h00ff);
    rd(RX_COUNT_OFS, 1'b0, 16'h0000);
    wr(6'h1f, 16'h1235);
    send(3'h2, 2);
    send(3'h5, 3);
    send(3'h0, 0);
    drain();
    // Mapped size and link settings only take effect through an init cycle; the threshold applies at once.
    wr(MAPPED_BYTE_COUNT_OFS, 16'h0005);
    wr(FULL_THRESHOLD_OFS, 16'h0004);
    wr(BAUD_OFS, 16'h0007);
    ctl(3'h0, 1'b1, 40'h0);
    wait_st(2, 1'b1);
    chk("init_link", 48'(link_enable), 48'h0);
    chk("init_baud", 48'(baud_cfg), 48'h7);
    ctl(3'h0, 1'b0, 40'h0);
    wait_st(2, 1'b0);
    @(posedge clk);
    #1;
    chk("ready_link", 48'(link_enable), 48'h1);
    send(3'h5, 5);
    // A pending mismatch holds the offer back until all test bytes are in.
    taken_tgl_q = 1'b1;
    ctl(3'h0, 1'b0, 40'h0);
    i_uart_end_model.put(8'h41, 3'h0);
    for (int k = 0; k < 3; k++) i_uart_end_model.put(8'h55, 3'h1 << k);
    i_uart_end_model.put(8'h42, 3'h0);
    taken_tgl_q = 1'b0;
    ctl(3'h0, 1'b0, 40'h0);
    wait_st(1, 1'b1);
    chk("rx_count", 48'(in_image[6:4]), 48'h2);
    chk("rx_bytes", 48'(in_image[23:8]), 48'h4241);
    i_uart_end_model.put(8'h43, 3'h0);
    repeat (30) @(posedge clk);
    #1;
    chk("rx_held", 48'(in_image[1]), 48'h1);
    taken_tgl_q = 1'b1;
    ctl(3'h0, 1'b0, 40'h0);
    wait_st(1, 1'b0);
    chk("rx_next", 48'({in_image[15:8], in_image[6:4]}), 48'({8'h43, 3'h1}));
    for (int k = 0; k < 5; k++) i_uart_end_model.put(8'(k + 1), 3'h0);
    repeat (4) @(posedge clk);
    #1;
    chk("buf_full", 48'(in_image[3]), 48'h1);
    rd(RX_COUNT_OFS, 1'b0, 16'h0004);
    rd(DIAG_ERROR_BITS_OFS, 1'b0, 16'h001f);
    drain();
    give_verdict();
  end
endmodule : serial_terminal_image_handshake_test

bind serial_terminal_image_handshake image_port_chk i_image_port_chk (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .pad_align(pad_align),
  .out_image(out_image), .in_image(in_image), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .link_enable(link_enable));
`default_nettype wire
